// ### rtl/rtb_dist.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Card acts as master or slave.
// - Bus carries at most ten lines.
// - Lines passed through generically.
// - Master accepts ten panel inputs.
// - Panel inputs resynchronised before bus drive.
// - All cards read timing from bus.
// - Front bus driven by master only.
// - Backplane bus follows same direction rule.
// - Backplane alongside or instead of front.
module rtb_dist
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_master_mode,
  input wire logic [1:0] i_path_sel,
  input wire logic [rtb_pkg::LINES-1:0] i_panel_in,
  input wire logic [rtb_pkg::LINES-1:0] i_front_in,
  output logic [rtb_pkg::LINES-1:0] o_front_out,
  output logic [rtb_pkg::LINES-1:0] o_front_oe,
  input wire logic [rtb_pkg::LINES-1:0] i_backplane_connector_bus_in,
  output logic [rtb_pkg::LINES-1:0] o_backplane_connector_bus_out,
  output logic [rtb_pkg::LINES-1:0] o_backplane_connector_bus_oe,
  output logic [rtb_pkg::LINES-1:0] o_timing
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    rtb_pkg::rtb_mode_e mode;
    logic [1:0] path;
    logic [rtb_pkg::LINES-1:0] drive;
    logic [rtb_pkg::LINES-1:0] front_oe;
    logic [rtb_pkg::LINES-1:0] back_oe;
    logic [rtb_pkg::LINES-1:0] timing;
  } rtb_dist_s;
  rtb_dist_s st_reg;
  rtb_dist_s st_next;
  logic [rtb_pkg::LINES-1:0] panel_sync;
  logic [rtb_pkg::LINES-1:0] front_sync;
  logic [rtb_pkg::LINES-1:0] back_sync;

  function automatic logic [rtb_pkg::LINES-1:0] fan(input logic en);
    fan = {rtb_pkg::LINES{en}};
  endfunction

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  rtb_sync u_panel_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_panel_in),
    .o_sync(panel_sync)
  );
  rtb_sync u_front_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_front_in),
    .o_sync(front_sync)
  );
  rtb_sync u_back_sync
  (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async(i_backplane_connector_bus_in),
    .o_sync(back_sync)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.mode = i_master_mode ? rtb_pkg::RTB_MASTER : rtb_pkg::RTB_SLAVE;
    st_next.path = (i_path_sel == 2'h0) ? rtb_pkg::PATH_FRONT : i_path_sel;
    st_next.drive = panel_sync;
    case (st_reg.mode)
      rtb_pkg::RTB_MASTER:
      begin
        st_next.front_oe = fan(st_reg.path[0]);
        st_next.back_oe = fan(st_reg.path[1]);
      end
      default:
      begin
        st_next.front_oe = rtb_pkg::LINES_RESET;
        st_next.back_oe = rtb_pkg::LINES_RESET;
      end
    endcase
    // Timing is read from the backplane only when the front bus is not selected
    if (st_reg.path[0])
    begin
      st_next.timing = front_sync;
    end
    else
    begin
      st_next.timing = back_sync;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      st_reg.mode <= rtb_pkg::RTB_SLAVE;
      st_reg.path <= rtb_pkg::PATH_FRONT;
      st_reg.drive <= rtb_pkg::LINES_RESET;
      st_reg.front_oe <= rtb_pkg::LINES_RESET;
      st_reg.back_oe <= rtb_pkg::LINES_RESET;
      st_reg.timing <= rtb_pkg::LINES_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_front_out = st_reg.drive;
  assign o_front_oe = st_reg.front_oe;
  assign o_backplane_connector_bus_out = st_reg.drive;
  assign o_backplane_connector_bus_oe = st_reg.back_oe;
  assign o_timing = st_reg.timing;
endmodule
`default_nettype wire

// ### rtl/rtb_pkg.sv
package rtb_pkg;
  // ----------------------------------------
  // Bus geometry and timing
  // ----------------------------------------
  localparam int unsigned LINES = 10;
  localparam int unsigned SYNC_STAGES = 2;
  localparam real CLK_MHZ = 40.0;
  localparam logic [9:0] LINES_RESET = 10'h000;
  localparam logic [1:0] PATH_FRONT = 2'h1;
  localparam logic [1:0] PATH_BACK = 2'h2;
  localparam logic [1:0] PATH_BOTH = 2'h3;
  typedef logic [LINES-1:0] rtb_lines_t;
  typedef enum logic [0:0] {
    RTB_SLAVE,
    RTB_MASTER
  } rtb_mode_e;
endpackage

// ### rtl/rtb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_sync
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic [rtb_pkg::LINES-1:0] i_async,
  output logic [rtb_pkg::LINES-1:0] o_sync
);
  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  typedef struct packed {
    logic [rtb_pkg::LINES-1:0] meta;
    logic [rtb_pkg::LINES-1:0] stable;
  } rtb_sync_s;
  rtb_sync_s st_reg;
  rtb_sync_s st_next;
  always_comb
  begin
    st_next.meta = i_async;
    st_next.stable = st_reg.meta;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign o_sync = st_reg.stable;
endmodule
`default_nettype wire

// ### verification/rtb_dist_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_dist_asserts
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_master_mode,
  input wire logic [1:0] i_path_sel,
  input wire logic [9:0] o_front_oe,
  input wire logic [9:0] i_panel_in,
  input wire logic [9:0] o_front_out,
  input wire logic [9:0] o_backplane_connector_bus_oe,
  input wire logic [9:0] o_backplane_connector_bus_out,
  input wire logic [9:0] o_timing
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence s_slave_req;
    !i_master_mode;
  endsequence
  sequence s_back_req;
    i_master_mode && i_path_sel[1];
  endsequence
  sequence s_run_three;
    !$past(i_sys_rst, 1) && !$past(i_sys_rst, 2) && !$past(i_sys_rst, 3);
  endsequence
  chk_back_off: assert property (s_slave_req |-> ##2 o_backplane_connector_bus_oe == 10'h000) else $error("back oe");
  chk_back_on: assert property (s_back_req |-> ##2 &o_backplane_connector_bus_oe) else $error("back on");
  chk_panel_drive: assert property (s_run_three |-> o_front_out == $past(i_panel_in, 3)) else $error("drive");
  chk_oe_uniform: assert property (o_front_oe == 10'h000 || &o_front_oe) else $error("oe mixed");
  chk_slave_off: assert property (!i_master_mode |-> ##2 o_front_oe == 10'h000) else $error("oe");
  chk_front_on: assert property (i_master_mode && i_path_sel != 2'h2 |-> ##2 &o_front_oe) else $error("on");
endmodule
bind rtb_dist rtb_dist_asserts i_rtb_dist_asserts (.*);
`default_nettype wire

// ### verification/rtb_far.sv
`timescale 1ns/1ps
`default_nettype none
module rtb_far
(
  input wire logic [9:0] i_out,
  input wire logic [9:0] i_oe,
  input wire logic [9:0] i_rem,
  output logic [9:0] o_wire
);
  assign o_wire = (i_out & i_oe) | (i_rem & ~i_oe);
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk_sys = 1'h0, i_sys_rst = 1'h1, i_master_mode = 1'h0;
  logic [1:0] i_path_sel = 2'h1;
  logic [9:0] i_panel_in = 10'h000, i_front_in, o_front_out, o_front_oe, o_timing;
  logic [9:0] i_backplane_connector_bus_in, o_backplane_connector_bus_out, o_backplane_connector_bus_oe;
  int miscompares = 0, samples_checked = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  rtb_dist i_rtb_dist (.*);
  rtb_far i_far_f (.i_out(o_front_out), .i_oe(o_front_oe), .i_rem(~i_panel_in), .o_wire(i_front_in));
  rtb_far i_far_b (.i_out(o_backplane_connector_bus_out), .i_oe(o_backplane_connector_bus_oe), .i_rem(~i_panel_in),
    .o_wire(i_backplane_connector_bus_in));
  task chk(input logic [9:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %0t %h", $time, got);
    end
  endtask
  task give_verdict(input int late);
    miscompares += late;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task t_card(input logic m, input logic [1:0] p, input logic [9:0] v);
    logic [1:0] q;
    q = (p == 2'h0) ? 2'h1 : p;
    i_master_mode <= m;
    i_path_sel <= p;
    i_panel_in <= v;
    repeat (8) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(o_front_oe, {10{m & q[0]}});
    chk(o_backplane_connector_bus_oe, {10{m & q[1]}});
    chk(o_timing, m ? v : ~v);
    chk(o_front_out, v);
    chk(o_backplane_connector_bus_out, v);
    @(posedge i_clk_sys);
  endtask
  task t_reset;
    i_sys_rst <= 1'h1;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(o_front_oe, 10'h000);
    chk(o_timing, 10'h000);
    chk(o_front_out, 10'h000);
    @(posedge i_clk_sys);
    i_sys_rst <= 1'h0;
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk_sys);
    i_sys_rst <= 1'h0;
    for (int p = 0; p < 4; p++)
      t_card(1'h1, p[1:0], 10'h2a5 << p);
    t_card(1'h0, 2'h1, 10'h0f3);
    t_card(1'h0, 2'h2, 10'h30c);
    t_reset();
    t_card(1'h1, 2'h3, 10'h1e7);
    give_verdict(0);
  end
  initial #6000 give_verdict(1);
endmodule
`default_nettype wire
